//--- design/mcsr_core_regs.sv
// core special-function registers: status, pointers, accumulator, config
// What this block does
// RULE1: special registers occupy upper 128 data bytes, direct access only.
// RULE2: fetch counter, opcode holder and register banks stay outside.
// RULE3: status at D0, result at E0, operand at F0, all bit addressable.
// RULE4: program control at 87, byte access only.
// RULE5: core configuration at AF, byte access only.
// RULE6: stack pointer at 81, byte access only.
// RULE7: carry bit 7 and overflow bit 2 follow add, addc, subb, mul, div.
// RULE8: nibble carry bit 6 follows only add and addc.
// RULE9: status bits 5 and 1 are user flags changed only by software.
// RULE10: status bits 4:3 select register bank 0 to 3.
// RULE11: status bit 0 keeps result register plus parity bit even.
// RULE12: program control bit 7 doubles baud rate, zero after reset.
// RULE13: software writes program control bits 6:0 as zero.
// RULE14: data pointer low byte at 82, zero after reset.
// RULE15: data pointer high byte at 83, zero after reset.
// RULE16: data pointer pair is high and low byte, not bit addressable.
// RULE17: stack pointer resets to 7.
// RULE18: four eight-byte banks fill the first 32 ram bytes.
// RULE19: parity bit is read-only; writes never override it.
`timescale 1ns/1ns
module mcsr_core_regs #(
  parameter int IDX_W = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // direct byte access from the core
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_indirect_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  // single-bit access
  input wire logic [7:0] bit_addr_i,
  input wire logic bit_wr_i,
  input wire logic bit_rd_i,
  input wire logic bit_wdata_i,
  output logic bit_rdata_o,
  // instruction side effects
  input wire mcsr_pkg::mcsr_alu_op_t alu_op_i,
  input wire logic alu_cy_i,
  input wire logic alu_ac_i,
  input wire logic alu_ov_i,
  input wire logic acc_we_i,
  input wire logic [7:0] acc_d_i,
  input wire logic b_we_i,
  input wire logic [7:0] b_d_i,
  input wire logic data_ptr_pair_we_i,
  input wire logic [15:0] data_ptr_pair_d_i,
  input wire logic sp_we_i,
  input wire logic [7:0] sp_d_i,
  input wire logic [IDX_W-1:0] reg_idx_i,
  // register contents toward the core
  output logic [7:0] acc_o,
  output logic [7:0] b_o,
  output logic [7:0] psw_o,
  output logic [15:0] data_ptr_pair_o,
  output logic [7:0] sp_o,
  output logic baud_doubler_o,
  output logic [7:0] core_config_o,
  output logic [mcsr_pkg::BANK_W+IDX_W-1:0] bank_reg_addr_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] program_status_word;
    logic [7:0] data_ptr_low;
    logic [7:0] data_ptr_high;
    logic [7:0] sp;
    logic baud;
    logic [7:0] cfg;
    logic [7:0] rdata;
    logic hit;
    logic bit_rdata;
  } mcsr_state_t;

  mcsr_state_t state_q;
  mcsr_state_t state_d;

  logic parity;
  logic dir_ok;
  logic bit_ok;
  logic [7:0] bit_byte;
  logic [mcsr_pkg::BIT_IDX_W-1:0] bit_idx;
  logic flag_op;
  logic nibble_op;
  logic [7:0] psw_view;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // parity is never stored, so no write path can disturb it
  mcsr_parity #(
    .WIDTH(8)
  ) u_parity (
    .data_i(state_q.acc),
    .parity_o(parity)
  ); // RULE11

  // banks sit outside this space; only their ram address is formed here
  mcsr_bank_addr #(
    .BANK_W(mcsr_pkg::BANK_W),
    .IDX_W(IDX_W)
  ) u_bank (
    .bank_select_i(state_q.program_status_word[mcsr_pkg::PSW_RS_HI:mcsr_pkg::PSW_RS_LO]),
    .reg_idx_i(reg_idx_i),
    .ram_addr_o(bank_reg_addr_o)
  ); // RULE10 RULE18 RULE2

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // indirect access to the upper half reaches ram, never these registers
  assign dir_ok = sfr_addr_i[mcsr_pkg::SFR_SPACE_BIT]
      & ~sfr_indirect_i; // RULE1
  assign bit_ok = bit_addr_i[mcsr_pkg::SFR_SPACE_BIT];
  assign bit_byte = {bit_addr_i[7:3], 3'h0};
  assign bit_idx = bit_addr_i[2:0];
  assign flag_op = alu_op_i inside {mcsr_pkg::MCSR_OP_ADD,
      mcsr_pkg::MCSR_OP_ADDC, mcsr_pkg::MCSR_OP_SUBB,
      mcsr_pkg::MCSR_OP_MUL, mcsr_pkg::MCSR_OP_DIV};
  assign nibble_op = alu_op_i inside {mcsr_pkg::MCSR_OP_ADD,
      mcsr_pkg::MCSR_OP_ADDC};
  assign psw_view = {state_q.program_status_word[7:1], parity}; // RULE19

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // instruction effects come last so they win over a software write
  always_comb begin
    state_d = state_q;
    // byte writes, only for registers of this space
    if (sfr_wr_i && dir_ok) begin
      unique case (sfr_addr_i)
        mcsr_pkg::ADDR_SP: state_d.sp = sfr_wdata_i; // RULE6
        mcsr_pkg::ADDR_DPL: state_d.data_ptr_low = sfr_wdata_i; // RULE14
        mcsr_pkg::ADDR_DPH: state_d.data_ptr_high = sfr_wdata_i; // RULE15
        mcsr_pkg::ADDR_PROGRAM_CONTROL: begin
          // reserved bits are not kept and read back zero
          state_d.baud = sfr_wdata_i[mcsr_pkg::PROGRAM_CONTROL_BAUD]; // RULE4 RULE12
        end
        mcsr_pkg::ADDR_CFG: state_d.cfg = sfr_wdata_i; // RULE5
        mcsr_pkg::ADDR_PSW: begin
          state_d.program_status_word = sfr_wdata_i; // RULE3 RULE9 RULE10
        end
        mcsr_pkg::ADDR_ACC: state_d.acc = sfr_wdata_i; // RULE3
        mcsr_pkg::ADDR_B: state_d.b = sfr_wdata_i; // RULE3
        default: begin
        end
      endcase
    end
    // bit writes reach only the three bit-addressable registers
    if (bit_wr_i && bit_ok) begin
      unique case (bit_byte)
        mcsr_pkg::ADDR_PSW: state_d.program_status_word[bit_idx] = bit_wdata_i; // RULE3
        mcsr_pkg::ADDR_ACC: state_d.acc[bit_idx] = bit_wdata_i; // RULE3
        mcsr_pkg::ADDR_B: state_d.b[bit_idx] = bit_wdata_i; // RULE3
        default: begin
        end
      endcase
    end
    // instruction results
    if (acc_we_i) begin
      state_d.acc = acc_d_i;
    end
    if (b_we_i) begin
      state_d.b = b_d_i;
    end
    if (data_ptr_pair_we_i) begin
      state_d.data_ptr_high = data_ptr_pair_d_i[15:8]; // RULE16
      state_d.data_ptr_low = data_ptr_pair_d_i[7:0]; // RULE16
    end
    if (sp_we_i) begin
      state_d.sp = sp_d_i;
    end
    // user flags are deliberately absent from this list
    if (flag_op) begin
      state_d.program_status_word[mcsr_pkg::PSW_CY] = alu_cy_i; // RULE7
      state_d.program_status_word[mcsr_pkg::PSW_OV] = alu_ov_i; // RULE7
    end
    if (nibble_op) begin
      state_d.program_status_word[mcsr_pkg::PSW_AC] = alu_ac_i; // RULE8
    end
    // stored parity slot is dead; the live value is substituted on read
    state_d.program_status_word[mcsr_pkg::PSW_P] = 1'b0; // RULE19
    // byte read, registered; unmapped addresses answer zero
    state_d.rdata = mcsr_pkg::RST_ZERO;
    state_d.hit = 1'b0;
    if (sfr_rd_i && dir_ok) begin
      state_d.hit = 1'b1;
      unique case (sfr_addr_i)
        mcsr_pkg::ADDR_SP: state_d.rdata = state_q.sp;
        mcsr_pkg::ADDR_DPL: state_d.rdata = state_q.data_ptr_low;
        mcsr_pkg::ADDR_DPH: state_d.rdata = state_q.data_ptr_high;
        mcsr_pkg::ADDR_PROGRAM_CONTROL: begin
          state_d.rdata = mcsr_pkg::RST_ZERO;
          state_d.rdata[mcsr_pkg::PROGRAM_CONTROL_BAUD] = state_q.baud;
        end
        mcsr_pkg::ADDR_CFG: state_d.rdata = state_q.cfg;
        mcsr_pkg::ADDR_PSW: state_d.rdata = psw_view;
        mcsr_pkg::ADDR_ACC: state_d.rdata = state_q.acc;
        mcsr_pkg::ADDR_B: state_d.rdata = state_q.b;
        default: state_d.hit = 1'b0;
      endcase
    end
    // bit read, registered, same three registers only
    state_d.bit_rdata = 1'b0;
    if (bit_rd_i && bit_ok) begin
      unique case (bit_byte)
        mcsr_pkg::ADDR_PSW: state_d.bit_rdata = psw_view[bit_idx];
        mcsr_pkg::ADDR_ACC: state_d.bit_rdata = state_q.acc[bit_idx];
        mcsr_pkg::ADDR_B: state_d.bit_rdata = state_q.b[bit_idx];
        default: state_d.bit_rdata = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= '0;
      state_q.sp <= mcsr_pkg::RST_SP; // RULE17
      state_q.data_ptr_low <= mcsr_pkg::RST_ZERO; // RULE14
      state_q.data_ptr_high <= mcsr_pkg::RST_ZERO; // RULE15
      state_q.baud <= 1'b0; // RULE12
      state_q.cfg <= mcsr_pkg::RST_CFG;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign acc_o = state_q.acc;
  assign b_o = state_q.b;
  assign psw_o = psw_view;
  assign data_ptr_pair_o = {state_q.data_ptr_high, state_q.data_ptr_low}; // RULE16
  assign sp_o = state_q.sp;
  assign baud_doubler_o = state_q.baud; // RULE12
  assign core_config_o = state_q.cfg;
  assign sfr_rdata_o = state_q.rdata;
  assign sfr_hit_o = state_q.hit;
  assign bit_rdata_o = state_q.bit_rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic psw_sw_touch;
  assign psw_sw_touch =
      (sfr_wr_i && dir_ok && sfr_addr_i == mcsr_pkg::ADDR_PSW)
      || (bit_wr_i && bit_ok && bit_byte == mcsr_pkg::ADDR_PSW);

  sequence s_dpl_wr;
    sfr_wr_i && dir_ok && sfr_addr_i == mcsr_pkg::ADDR_DPL && !data_ptr_pair_we_i;
  endsequence

  sequence s_dph_wr;
    sfr_wr_i && dir_ok && sfr_addr_i == mcsr_pkg::ADDR_DPH && !data_ptr_pair_we_i;
  endsequence

  a_parity_even: assert property ( // RULE11
      !(^{acc_o, psw_o[mcsr_pkg::PSW_P]}))
    else $error("result register plus parity bit is odd");

  a_sp_reset: assert property (disable iff (1'b0) // RULE17
      $past(rst_i) |-> sp_o == mcsr_pkg::RST_SP)
    else $error("stack pointer not 7 after reset");

  a_user_flags_hold: assert property (!psw_sw_touch |=> // RULE9
      $stable(psw_o[mcsr_pkg::PSW_F0]) && $stable(psw_o[mcsr_pkg::PSW_F1]))
    else $error("user flag changed without a software write");

  a_carry_ov_update: assert property (flag_op |=> // RULE7
      psw_o[mcsr_pkg::PSW_CY] == $past(alu_cy_i)
      && psw_o[mcsr_pkg::PSW_OV] == $past(alu_ov_i))
    else $error("carry or overflow missed an arithmetic update");

  a_nibble_only_add: assert property (!nibble_op && !psw_sw_touch |=> // RULE8
      $stable(psw_o[mcsr_pkg::PSW_AC]))
    else $error("nibble carry changed outside add");

  a_indirect_blocked: assert property (sfr_wr_i && sfr_indirect_i // RULE1
      && !bit_wr_i |=> $stable(baud_doubler_o) && $stable(core_config_o))
    else $error("indirect write reached a special register");

  a_program_control_no_bits: assert property (bit_wr_i // RULE4
      && !(sfr_wr_i && dir_ok)
      |=> $stable(baud_doubler_o) && $stable(core_config_o))
    else $error("bit write changed a byte-only register");

  a_data_ptr_pair_pair: assert property (s_dpl_wr ##1 s_dph_wr |=> // RULE16
      data_ptr_pair_o == {$past(sfr_wdata_i), $past(sfr_wdata_i, 2)})
    else $error("data pointer pair does not hold written bytes");

  a_read_acc: assert property (sfr_rd_i && dir_ok // RULE3
      && sfr_addr_i == mcsr_pkg::ADDR_ACC |=>
      sfr_rdata_o == $past(acc_o) && sfr_hit_o)
    else $error("result register read returned wrong data");

  a_bank_address: assert property (bank_reg_addr_o == // RULE10
      {psw_o[mcsr_pkg::PSW_RS_HI:mcsr_pkg::PSW_RS_LO], reg_idx_i})
    else $error("bank address does not follow bank select");

endmodule : mcsr_core_regs

//--- design/mcsr_pkg.sv
// shared constants for the core special-function register block
package mcsr_pkg;

  // ----------------------------------------------------------------
  // address space
  // ----------------------------------------------------------------
  // direct addresses with bit 7 set belong to the special space
  localparam int SFR_SPACE_BIT = 7;
  localparam logic [7:0] ADDR_SP = 8'h81;
  localparam logic [7:0] ADDR_DPL = 8'h82;
  localparam logic [7:0] ADDR_DPH = 8'h83;
  localparam logic [7:0] ADDR_PROGRAM_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_CFG = 8'hAF;
  localparam logic [7:0] ADDR_PSW = 8'hD0;
  localparam logic [7:0] ADDR_ACC = 8'hE0;
  localparam logic [7:0] ADDR_B = 8'hF0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_SP = 8'h07;
  localparam logic [7:0] RST_CFG = 8'h81;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_F1 = 1;
  localparam int PSW_P = 0;
  localparam int PROGRAM_CONTROL_BAUD = 7;
  localparam int BIT_IDX_W = 3;
  localparam int BANK_W = 2;

  // ----------------------------------------------------------------
  // instruction class driving the flag update, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    MCSR_OP_NONE  = 7'h01,
    MCSR_OP_ADD   = 7'h02,
    MCSR_OP_ADDC  = 7'h04,
    MCSR_OP_SUBB  = 7'h08,
    MCSR_OP_MUL   = 7'h10,
    MCSR_OP_DIV   = 7'h20,
    MCSR_OP_OTHER = 7'h40
  } mcsr_alu_op_t;

endpackage : mcsr_pkg

//--- design/mcsr_parity.sv
// even-parity bit generator for the arithmetic result register
`timescale 1ns/1ns
module mcsr_parity #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] data_i,
  output logic parity_o
);

  // ----------------------------------------------------------------
  // running xor, one stage per bit
  // ----------------------------------------------------------------
  logic [WIDTH:0] chain;

  assign chain[0] = 1'b0;
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_xor
      assign chain[gi+1] = chain[gi] ^ data_i[gi];
    end
  endgenerate

  // high when the data holds an odd count of ones, so the sum is even
  assign parity_o = chain[WIDTH];

endmodule : mcsr_parity

//--- design/mcsr_bank_addr.sv
// register-bank address former: bank select plus register index
`timescale 1ns/1ns
module mcsr_bank_addr #(
  parameter int BANK_W = 2,
  parameter int IDX_W = 3
) (
  input wire logic [BANK_W-1:0] bank_select_i,
  input wire logic [IDX_W-1:0] reg_idx_i,
  output logic [BANK_W+IDX_W-1:0] ram_addr_o
);

  // ----------------------------------------------------------------
  // banks of eight bytes stacked from ram address zero
  // ----------------------------------------------------------------
  assign ram_addr_o = {bank_select_i, reg_idx_i};

endmodule : mcsr_bank_addr

//--- testbench/mcu_core_special_registers_tb.sv
// self-checking bench for the core special-function register block
`timescale 1ns/1ns
module mcu_core_special_registers_tb;
  // ------------------------------------------------------------------
  // signals, tables and design instance
  // ------------------------------------------------------------------
  logic clk_i, rst_i, sfr_indirect_i, sfr_wr_i, sfr_rd_i, sfr_hit_o;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, bit_addr_i;
  logic bit_wr_i, bit_rd_i, bit_wdata_i, bit_rdata_o;
  mcsr_pkg::mcsr_alu_op_t alu_op_i;
  logic alu_cy_i, alu_ac_i, alu_ov_i, acc_we_i, b_we_i, data_ptr_pair_we_i, sp_we_i;
  logic [7:0] acc_d_i, b_d_i, sp_d_i, acc_o, b_o, psw_o, sp_o, core_config_o;
  logic [15:0] data_ptr_pair_d_i, data_ptr_pair_o;
  logic [2:0] reg_idx_i;
  logic baud_doubler_o;
  logic [4:0] bank_reg_addr_o;
  int failures = 0;
  int n_compared = 0;
  logic [31:0] lfsr_q = 32'hAEA1C656;
  logic [7:0] wv [8];
  logic [7:0] m [3];
  logic [7:0] x, y, p, e, rd_d;
  logic rd_h, r;
  int k;
  // acc first, so the parity expected for later status writes is known
  localparam logic [7:0] MAP [8] = '{mcsr_pkg::ADDR_ACC, mcsr_pkg::ADDR_B,
    mcsr_pkg::ADDR_PSW, mcsr_pkg::ADDR_PROGRAM_CONTROL, mcsr_pkg::ADDR_DPL,
    mcsr_pkg::ADDR_DPH, mcsr_pkg::ADDR_SP, mcsr_pkg::ADDR_CFG};
  localparam logic [7:0] BB [3] = '{8'hD0, 8'hE0, 8'hF0};
  localparam logic [7:0] NB [5] = '{8'h87, 8'h81, 8'h82, 8'h83, 8'hAF};
  localparam mcsr_pkg::mcsr_alu_op_t OPS [7] = '{mcsr_pkg::MCSR_OP_NONE,
    mcsr_pkg::MCSR_OP_ADD, mcsr_pkg::MCSR_OP_ADDC, mcsr_pkg::MCSR_OP_SUBB,
    mcsr_pkg::MCSR_OP_MUL, mcsr_pkg::MCSR_OP_DIV, mcsr_pkg::MCSR_OP_OTHER};

  mcsr_core_regs #(.IDX_W(3)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .sfr_addr_i(sfr_addr_i), .sfr_indirect_i(sfr_indirect_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o), .bit_addr_i(bit_addr_i),
    .bit_wr_i(bit_wr_i), .bit_rd_i(bit_rd_i), .bit_wdata_i(bit_wdata_i),
    .bit_rdata_o(bit_rdata_o), .alu_op_i(alu_op_i), .alu_cy_i(alu_cy_i),
    .alu_ac_i(alu_ac_i), .alu_ov_i(alu_ov_i), .acc_we_i(acc_we_i),
    .acc_d_i(acc_d_i), .b_we_i(b_we_i), .b_d_i(b_d_i), .data_ptr_pair_we_i(data_ptr_pair_we_i),
    .data_ptr_pair_d_i(data_ptr_pair_d_i), .sp_we_i(sp_we_i), .sp_d_i(sp_d_i),
    .reg_idx_i(reg_idx_i), .acc_o(acc_o), .b_o(b_o), .psw_o(psw_o),
    .data_ptr_pair_o(data_ptr_pair_o), .sp_o(sp_o), .baud_doubler_o(baud_doubler_o),
    .core_config_o(core_config_o), .bank_reg_addr_o(bank_reg_addr_o));

  // 25 MHz core clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------------
  // helpers: random source, expectations, bus cycles, report
  // ------------------------------------------------------------------
  task automatic rnd(output logic [7:0] v);
    for (int i = 0; i < 8; i++) lfsr_q = {lfsr_q[30:0],
      lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    v = lfsr_q[7:0];
  endtask : rnd

  // byte read-back: control keeps only its top bit, parity is always live
  function automatic logic [7:0] exp_byte(input logic [7:0] a, w, acc);
    if (a == mcsr_pkg::ADDR_PROGRAM_CONTROL) return {w[7], 7'h00};
    if (a == mcsr_pkg::ADDR_PSW) return {w[7:1], ^acc};
    return w;
  endfunction : exp_byte

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("compared %0d, failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // all tasks enter and leave on a falling edge; the trailing idle
  // cycle keeps a strobe from being lowered and raised in one step
  task automatic sfr_wr(input logic [7:0] a, d, input logic ind);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_indirect_i = ind;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
    sfr_indirect_i = 1'b0;
    @(negedge clk_i);
  endtask : sfr_wr

  task automatic sfr_rd(input logic [7:0] a, input logic ind,
                        output logic [7:0] d, output logic h);
    sfr_addr_i = a;
    sfr_indirect_i = ind;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    sfr_indirect_i = 1'b0;
    d = sfr_rdata_o;
    h = sfr_hit_o;
    @(negedge clk_i);
  endtask : sfr_rd

  task automatic bit_acc(input logic [7:0] a, input logic wr, v,
                         output logic rb);
    bit_addr_i = a;
    bit_wdata_i = v;
    bit_wr_i = wr;
    bit_rd_i = ~wr;
    @(negedge clk_i);
    bit_wr_i = 1'b0;
    bit_rd_i = 1'b0;
    rb = bit_rdata_o;
    @(negedge clk_i);
  endtask : bit_acc

  task automatic do_reset();
    rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
  endtask : do_reset

  task automatic reset_values();
    check(acc_o, 8'h00);
    check(psw_o, 8'h00);
    check(data_ptr_pair_o, 16'h0000);
    check(sp_o, mcsr_pkg::RST_SP);
    check(baud_doubler_o, 1'b0);
    check(core_config_o, mcsr_pkg::RST_CFG);
    check({sfr_hit_o, sfr_rdata_o}, 9'h000);
  endtask : reset_values

  // cut a hang short
  initial begin
    #400000;
    failures++;
    wrap_up();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {sfr_indirect_i, sfr_wr_i, sfr_rd_i, bit_wr_i, bit_rd_i} = 5'h00;
    {alu_cy_i, alu_ac_i, alu_ov_i, bit_wdata_i} = 4'h0;
    {acc_we_i, b_we_i, data_ptr_pair_we_i, sp_we_i} = 4'h0;
    {sfr_addr_i, sfr_wdata_i, bit_addr_i, acc_d_i, b_d_i} = 40'h0;
    {sp_d_i, data_ptr_pair_d_i, reg_idx_i} = 27'h0;
    alu_op_i = mcsr_pkg::MCSR_OP_NONE;
    do_reset();
    reset_values();
    $display("test reset values done");
    // every mapped byte written and read back
    for (int i = 0; i < 8; i++) begin
      rnd(wv[i]);
      if (i == 2) wv[i][0] = ~^wv[0];
      if (i == 3) wv[i] = 8'h80;
      sfr_wr(MAP[i], wv[i], 1'b0);
      sfr_rd(MAP[i], 1'b0, rd_d, rd_h);
      check(rd_d, exp_byte(MAP[i], wv[i], wv[0]));
      check(rd_h, 1'b1);
    end
    check({sfr_hit_o, sfr_rdata_o}, 9'h000);
    check(psw_o, exp_byte(mcsr_pkg::ADDR_PSW, wv[2], wv[0]));
    check(baud_doubler_o, 1'b1);
    check(data_ptr_pair_o, {wv[5], wv[4]});
    check(sp_o, wv[6]);
    check(core_config_o, wv[7]);
    $display("test byte map done");
    // indirect, lower-half and unmapped accesses are ignored
    sfr_wr(mcsr_pkg::ADDR_ACC, ~wv[0], 1'b1);
    check(acc_o, wv[0]);
    sfr_rd(mcsr_pkg::ADDR_ACC, 1'b1, rd_d, rd_h);
    check({rd_h, rd_d}, 9'h000);
    sfr_rd(8'h60, 1'b0, rd_d, rd_h);
    check({rd_h, rd_d}, 9'h000);
    sfr_rd(8'h85, 1'b0, rd_d, rd_h);
    check({rd_h, rd_d}, 9'h000);
    // byte-only registers must ignore single-bit writes of either value
    foreach (NB[i]) for (int v = 0; v < 2; v++) bit_acc(NB[i], 1'b1, v[0], r);
    check(baud_doubler_o, 1'b1);
    check(sp_o, wv[6]);
    check(data_ptr_pair_o, {wv[5], wv[4]});
    check(core_config_o, wv[7]);
    $display("test refusals done");
    // random bit writes and reads on the three bit-addressable bytes
    m[0] = wv[2];
    m[1] = wv[0];
    m[2] = wv[1];
    repeat (24) begin
      rnd(x);
      k = x[5:4] % 3;
      bit_acc({BB[k][7:3], x[2:0]}, 1'b1, x[3], r);
      if (k != 0 || x[2:0] != 3'h0) m[k][x[2:0]] = x[3];
      rnd(y);
      k = y[5:4] % 3;
      bit_acc({BB[k][7:3], y[2:0]}, 1'b0, 1'b0, r);
      check(r, (k == 0 && y[2:0] == 3'h0) ? ^m[1] : m[k][y[2:0]]);
      check(psw_o, {m[0][7:1], ^m[1]});
      check(acc_o, m[1]);
      check(b_o, m[2]);
    end
    $display("test bit access done");
    // every instruction class against flags set opposite beforehand
    for (int j = 0; j < 14; j++) begin
      rnd(x);
      p = {~x[0], ~x[1], x[5], x[4:3], ~x[2], x[6], 1'b0};
      sfr_wr(mcsr_pkg::ADDR_PSW, p, 1'b0);
      alu_op_i = OPS[j % 7];
      {alu_cy_i, alu_ac_i, alu_ov_i} = {x[0], x[1], x[2]};
      reg_idx_i = x[7:5];
      @(negedge clk_i);
      alu_op_i = mcsr_pkg::MCSR_OP_NONE;
      e = {p[7:1], ^m[1]};
      if (j % 7 >= 1 && j % 7 <= 5) {e[7], e[2]} = {x[0], x[2]};
      if (j % 7 == 1 || j % 7 == 2) e[6] = x[1];
      check(psw_o, e);
      check(bank_reg_addr_o, {e[4:3], x[7:5]});
    end
    $display("test flag updates done");
    // instruction loads win over a software write in the same cycle
    repeat (12) begin
      rnd(x);
      rnd(y);
      {acc_d_i, b_d_i, sp_d_i, data_ptr_pair_d_i} = {x, ~x, y, x, y};
      {acc_we_i, b_we_i, sp_we_i, data_ptr_pair_we_i} = 4'hF;
      sfr_addr_i = mcsr_pkg::ADDR_ACC;
      sfr_wdata_i = y;
      sfr_wr_i = 1'b1;
      @(negedge clk_i);
      {acc_we_i, b_we_i, sp_we_i, data_ptr_pair_we_i, sfr_wr_i} = 5'h00;
      check({acc_o, b_o}, {x, ~x});
      check(psw_o[0], ^x);
      check(sp_o, y);
      check(data_ptr_pair_o, {x, y});
      sfr_rd(mcsr_pkg::ADDR_DPL, 1'b0, rd_d, rd_h);
      check(rd_d, y);
      sfr_rd(mcsr_pkg::ADDR_DPH, 1'b0, rd_d, rd_h);
      check(rd_d, x);
    end
    $display("test instruction loads done");
    // low then high pointer byte on back-to-back cycles, strobe held up
    rnd(x);
    rnd(y);
    sfr_addr_i = mcsr_pkg::ADDR_DPL;
    sfr_wdata_i = x;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_addr_i = mcsr_pkg::ADDR_DPH;
    sfr_wdata_i = y;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
    check(data_ptr_pair_o, {y, x});
    @(negedge clk_i);
    check(data_ptr_pair_o, {y, x});
    $display("test pointer pair done");
    do_reset();
    reset_values();
    $display("test second reset done");
    wrap_up();
  end
endmodule : mcu_core_special_registers_tb
